// *** inc/serial_pkg.sv ***
package serial_pkg;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned TX_FIFO_AW = 4;

	// Bit select codes for writes from the CPU
	localparam logic [4:0] WR_RESET = 5'h1F;
	localparam logic [4:0] WR_MODEM_EN = 5'h15;
	localparam logic [4:0] WR_TIMER_EN = 5'h14;
	localparam logic [4:0] WR_TX_EN = 5'h13;
	localparam logic [4:0] WR_RX_EN = 5'h12;
	localparam logic [4:0] WR_BREAK = 5'h11;
	localparam logic [4:0] WR_RTS = 5'h10;
	localparam logic [4:0] WR_TXB_TOP = 5'h07;

	// Bit select codes for status reads
	localparam int unsigned RD_INT = 31;
	localparam int unsigned RD_FLAG = 30;
	localparam int unsigned RD_MODEM_LINE_CHANGED = 29;
	localparam int unsigned RD_CTS = 28;
	localparam int unsigned RD_DSR = 27;
	localparam int unsigned RD_RTS = 26;
	localparam int unsigned RD_TIMELAPSE = 25;
	localparam int unsigned RD_TIMEOVR = 24;
	localparam int unsigned RD_TXSE = 23;
	localparam int unsigned RD_TXHE = 22;
	localparam int unsigned RD_RXFULL = 21;
	localparam int unsigned RD_MODEM_IRQ = 20;
	localparam int unsigned RD_TIMER_IRQ = 19;
	localparam int unsigned RD_TX_IRQ = 17;
	localparam int unsigned RD_RX_IRQ = 16;
	localparam int unsigned RD_RXLINE = 15;
	localparam int unsigned RD_START = 14;
	localparam int unsigned RD_FIRST = 13;
	localparam int unsigned RD_FRAME = 12;
	localparam int unsigned RD_OVER = 11;
	localparam int unsigned RD_PAR = 10;
	localparam int unsigned RD_ANYERR = 9;

	localparam logic [5:0] PRESCALE_LAST = 6'h3F;
	localparam logic [1:0] STOP_1P5 = 2'h0;
	localparam logic [1:0] STOP_2 = 2'h1;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_START = 3'b001,
		TX_DATA = 3'b010,
		TX_PARITY = 3'b011,
		TX_STOP = 3'b100,
		TX_BREAK = 3'b101
	} tx_state_t;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_HALF = 3'b001,
		RX_BITS = 3'b010,
		RX_STOP = 3'b011,
		RX_WAIT_HIGH = 3'b100
	} rx_state_t;

	typedef struct packed {
		logic we;
		logic [4:0] addr;
		logic wdata;
	} cru_req_t;

	typedef struct packed {
		logic char_length_sel_hi;
		logic char_length_sel_lo;
		logic stop_bits_sel_hi;
		logic stop_bits_sel_lo;
		logic parity_en;
		logic parity_odd;
		logic [15:0] bit_cycles;
		logic [7:0] interval;
	} cfg_t;
endpackage

// *** verilog/serial_tx_status.sv ***
`timescale 1ns/1ps
module tx_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16,
	parameter int unsigned AW = 4
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;

	assign out_valid = wr_ptr != rd_ptr;
	assign in_ready = (wr_ptr[AW] == rd_ptr[AW]) ||
		(wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
	assign out_data = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge clk_sys) begin
		if (!rst_n || flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (out_valid && out_ready) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (in_valid && in_ready) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end
endmodule

module serial_tx_status (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire serial_pkg::cru_req_t cru_req,
	output logic cru_rdata,
	input wire serial_pkg::cfg_t cfg,
	input wire logic serial_rx_line,
	input wire logic cts_n,
	input wire logic dsr_n,
	output logic serial_tx_line,
	output logic rts_n
);
	import serial_pkg::*;

	typedef struct packed {
		logic [2:0] rx_s;
		logic [2:0] cts_s;
		logic [2:0] dsr_s;
		logic rx_lvl;
		logic rx_prev;
		logic cts_lvl;
		logic dsr_lvl;
		logic modem_change_irq_enable;
		logic timer_irq_enable;
		logic tx_irq_enable;
		logic rx_irq_enable;
		logic break_request;
		logic request_send_control;
		logic modem_line_changed;
		logic timer_expired_flag;
		logic timer_overrun_flag;
		logic tx_holding_empty;
		logic tx_shifter_empty;
		logic rx_holding_full;
		logic start_bit_seen;
		logic first_bit_seen;
		logic stop_bit_error;
		logic rx_overrun_flag;
		logic rx_parity_flag;
		logic [7:0] tx_holding;
		logic [7:0] received_character_buffer;
		tx_state_t tx_state;
		logic [15:0] tx_cnt;
		logic [3:0] tx_bits;
		logic [7:0] tx_shift;
		logic tx_par;
		logic serial_tx_line;
		logic rts_n;
		rx_state_t rx_state;
		logic [15:0] rx_cnt;
		logic [3:0] rx_idx;
		logic [7:0] rx_shift;
		logic rx_par;
		logic [5:0] pre_cnt;
		logic [7:0] timer_cnt;
		logic rdata;
	} state_t;

	state_t s_reg;
	state_t s_next;
	logic [31:0] status;
	logic [3:0] char_len;
	logic [7:0] len_mask;
	logic [15:0] half_cycles;
	logic [15:0] stop_cycles;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [7:0] fifo_out_data;
	logic fifo_flush;
	logic tx_enabled;
	logic timer_hit;
	logic reset_cmd;

	assign char_len = 4'h5 + {2'b00, cfg.char_length_sel_hi,
		cfg.char_length_sel_lo};
	assign len_mask = 8'hFF >> (4'h8 - char_len);
	assign half_cycles = cfg.bit_cycles >> 1;
	always_comb begin
		unique case ({cfg.stop_bits_sel_hi, cfg.stop_bits_sel_lo})
			STOP_1P5: stop_cycles = cfg.bit_cycles + half_cycles;
			STOP_2: stop_cycles = cfg.bit_cycles << 1;
			default: stop_cycles = cfg.bit_cycles;
		endcase
	end

	assign reset_cmd = cru_req.we && cru_req.addr == WR_RESET;
	assign tx_enabled = !s_reg.rts_n && !s_reg.cts_lvl;
	// Break freezes the path into the FIFO so nothing can follow it
	assign fifo_in_valid = !s_reg.tx_holding_empty &&
		s_reg.tx_state != TX_BREAK;
	assign fifo_out_ready = s_reg.tx_state == TX_IDLE && tx_enabled;
	assign fifo_flush = reset_cmd;
	assign timer_hit = s_reg.pre_cnt == 6'h00 && s_reg.timer_cnt <= 8'h01;

	tx_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .AW(TX_FIFO_AW)) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.flush(fifo_flush),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(s_reg.tx_holding),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	always_comb begin
		status = '0;
		status[RD_FLAG] = s_reg.break_request;
		status[RD_MODEM_LINE_CHANGED] = s_reg.modem_line_changed;
		status[RD_CTS] = !s_reg.cts_lvl;
		status[RD_DSR] = !s_reg.dsr_lvl;
		status[RD_RTS] = !s_reg.rts_n;
		status[RD_TIMELAPSE] = s_reg.timer_expired_flag;
		status[RD_TIMEOVR] = s_reg.timer_overrun_flag;
		status[RD_TXSE] = s_reg.tx_shifter_empty;
		status[RD_TXHE] = s_reg.tx_holding_empty;
		status[RD_RXFULL] = s_reg.rx_holding_full;
		status[RD_MODEM_IRQ] = s_reg.modem_line_changed &
			s_reg.modem_change_irq_enable;
		status[RD_TIMER_IRQ] = s_reg.timer_expired_flag &
			s_reg.timer_irq_enable;
		status[RD_TX_IRQ] = s_reg.tx_holding_empty &
			s_reg.tx_irq_enable;
		status[RD_RX_IRQ] = s_reg.rx_holding_full &
			s_reg.rx_irq_enable;
		status[RD_INT] = status[RD_MODEM_IRQ] | status[RD_TIMER_IRQ] |
			status[RD_TX_IRQ] | status[RD_RX_IRQ];
		status[RD_RXLINE] = s_reg.rx_lvl;
		status[RD_START] = s_reg.start_bit_seen;
		status[RD_FIRST] = s_reg.first_bit_seen;
		status[RD_FRAME] = s_reg.stop_bit_error;
		status[RD_OVER] = s_reg.rx_overrun_flag;
		status[RD_PAR] = s_reg.rx_parity_flag;
		status[RD_ANYERR] = s_reg.stop_bit_error | s_reg.rx_overrun_flag |
			s_reg.rx_parity_flag;
		status[7:0] = s_reg.received_character_buffer;
	end

	always_comb begin
		s_next = s_reg;
		s_next.rdata = status[cru_req.addr];
		// Pins: a change is accepted once the last two stages agree
		s_next.rx_s = {s_reg.rx_s[1:0], serial_rx_line};
		s_next.cts_s = {s_reg.cts_s[1:0], cts_n};
		s_next.dsr_s = {s_reg.dsr_s[1:0], dsr_n};
		if (s_reg.rx_s[1] == s_reg.rx_s[2]) begin
			s_next.rx_lvl = s_reg.rx_s[2];
		end
		if (s_reg.cts_s[1] == s_reg.cts_s[2]) begin
			s_next.cts_lvl = s_reg.cts_s[2];
		end
		if (s_reg.dsr_s[1] == s_reg.dsr_s[2]) begin
			s_next.dsr_lvl = s_reg.dsr_s[2];
		end
		s_next.rx_prev = s_reg.rx_lvl;

		// CPU writes first, so hardware sets below win over their clears; the reset command is applied last and wins over them
		if (cru_req.we) begin
			unique case (cru_req.addr)
				WR_MODEM_EN: begin
					s_next.modem_change_irq_enable = cru_req.wdata;
					s_next.modem_line_changed = 1'b0;
				end
				WR_TIMER_EN: begin
					s_next.timer_irq_enable = cru_req.wdata;
					s_next.timer_expired_flag = 1'b0;
					s_next.timer_overrun_flag = 1'b0;
				end
				WR_TX_EN: s_next.tx_irq_enable = cru_req.wdata;
				WR_RX_EN: begin
					s_next.rx_irq_enable = cru_req.wdata;
					s_next.rx_holding_full = 1'b0;
				end
				WR_BREAK: s_next.break_request = cru_req.wdata;
				WR_RTS: s_next.request_send_control = cru_req.wdata;
				default: begin
					if (cru_req.addr <= WR_TXB_TOP &&
						s_reg.tx_state != TX_BREAK) begin
						s_next.tx_holding[cru_req.addr[2:0]] = cru_req.wdata;
					end
				end
			endcase
		end

		if (s_reg.cts_lvl != s_next.cts_lvl ||
			s_reg.dsr_lvl != s_next.dsr_lvl) begin
			s_next.modem_line_changed = 1'b1;
		end

		// Interval timer
		s_next.pre_cnt = s_reg.pre_cnt - 6'h01;
		if (s_reg.pre_cnt == 6'h00) begin
			s_next.pre_cnt = PRESCALE_LAST;
			s_next.timer_cnt = s_reg.timer_cnt - 8'h01;
			if (timer_hit) begin
				s_next.timer_cnt = cfg.interval;
				s_next.timer_expired_flag = 1'b1;
				if (s_reg.timer_expired_flag) begin
					s_next.timer_overrun_flag = 1'b1;
				end
			end
		end

		// Holding register drains into the FIFO
		if (fifo_in_valid && fifo_in_ready) begin
			s_next.tx_holding_empty = 1'b1;
		end
		if (cru_req.we && cru_req.addr == WR_TXB_TOP &&
			s_reg.tx_state != TX_BREAK) begin
			s_next.tx_holding_empty = 1'b0;
		end

		if (s_reg.request_send_control) begin
			s_next.rts_n = 1'b0;
		end else if (s_reg.tx_holding_empty && !fifo_out_valid &&
			s_reg.tx_state == TX_IDLE && !s_reg.break_request) begin
			s_next.rts_n = 1'b1;
		end

		s_next.tx_cnt = s_reg.tx_cnt - 16'h0001;
		unique case (s_reg.tx_state)
			TX_IDLE: begin
				s_next.serial_tx_line = 1'b1;
				s_next.tx_shifter_empty = 1'b1;
				if (fifo_out_valid && tx_enabled) begin
					s_next.tx_shift = fifo_out_data & len_mask;
					// Parity is fixed at load, the shifter is empty by then
					s_next.tx_par = ^(fifo_out_data & len_mask) ^
						cfg.parity_odd;
					s_next.tx_state = TX_START;
					s_next.tx_shifter_empty = 1'b0;
					s_next.serial_tx_line = 1'b0;
					s_next.tx_cnt = cfg.bit_cycles - 16'h0001;
				end else if (s_reg.break_request && tx_enabled &&
					s_reg.tx_holding_empty && !fifo_out_valid) begin
					s_next.tx_state = TX_BREAK;
					s_next.serial_tx_line = 1'b0;
				end
			end
			TX_START, TX_DATA: begin
				if (s_reg.tx_cnt == 16'h0000) begin
					s_next.tx_cnt = cfg.bit_cycles - 16'h0001;
					if (s_reg.tx_state == TX_START) begin
						s_next.tx_bits = char_len - 4'h1;
					end else begin
						s_next.tx_bits = s_reg.tx_bits - 4'h1;
					end
					if (s_reg.tx_state == TX_START ||
						s_reg.tx_bits != 4'h0) begin
						s_next.tx_state = TX_DATA;
						s_next.serial_tx_line = s_reg.tx_shift[0];
						s_next.tx_shift = s_reg.tx_shift >> 1;
					end else if (cfg.parity_en) begin
						s_next.tx_state = TX_PARITY;
						s_next.serial_tx_line = s_reg.tx_par;
					end else begin
						s_next.tx_state = TX_STOP;
						s_next.serial_tx_line = 1'b1;
						s_next.tx_cnt = stop_cycles - 16'h0001;
					end
				end
			end
			TX_PARITY: begin
				if (s_reg.tx_cnt == 16'h0000) begin
					s_next.tx_state = TX_STOP;
					s_next.serial_tx_line = 1'b1;
					s_next.tx_cnt = stop_cycles - 16'h0001;
				end
			end
			TX_STOP: begin
				if (s_reg.tx_cnt == 16'h0000) begin
					s_next.tx_state = TX_IDLE;
					s_next.tx_shifter_empty = 1'b1;
				end
			end
			TX_BREAK: begin
				s_next.serial_tx_line = 1'b0;
				if (!s_reg.break_request) begin
					s_next.tx_state = TX_IDLE;
					s_next.serial_tx_line = 1'b1;
				end
			end
			default: s_next.tx_state = TX_IDLE;
		endcase

		s_next.rx_cnt = s_reg.rx_cnt - 16'h0001;
		unique case (s_reg.rx_state)
			RX_IDLE: begin
				if (s_reg.rx_prev && !s_reg.rx_lvl) begin
					s_next.rx_state = RX_HALF;
					s_next.rx_cnt = half_cycles - 16'h0001;
				end
			end
			RX_HALF: begin
				if (s_reg.rx_cnt == 16'h0000) begin
					s_next.start_bit_seen = !s_reg.rx_lvl;
					s_next.rx_state = s_reg.rx_lvl ? RX_IDLE : RX_BITS;
					s_next.rx_cnt = cfg.bit_cycles - 16'h0001;
					s_next.rx_idx = 4'h0;
					s_next.rx_shift = 8'h00;
				end
			end
			RX_BITS: begin
				if (s_reg.rx_cnt == 16'h0000) begin
					s_next.first_bit_seen = 1'b1;
					s_next.rx_cnt = cfg.bit_cycles - 16'h0001;
					s_next.rx_idx = s_reg.rx_idx + 4'h1;
					if (s_reg.rx_idx < char_len) begin
						s_next.rx_shift[s_reg.rx_idx[2:0]] = s_reg.rx_lvl;
					end else begin
						s_next.rx_par = s_reg.rx_lvl;
					end
					if (s_reg.rx_idx == char_len ||
						(s_reg.rx_idx == char_len - 4'h1 &&
						!cfg.parity_en)) begin
						s_next.rx_state = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (s_reg.rx_cnt == 16'h0000) begin
					s_next.received_character_buffer =
						s_reg.rx_shift & len_mask;
					s_next.rx_overrun_flag = s_reg.rx_holding_full;
					s_next.rx_holding_full = 1'b1;
					s_next.rx_parity_flag = cfg.parity_en &&
						((^s_reg.rx_shift ^ s_reg.rx_par) != cfg.parity_odd);
					s_next.stop_bit_error = !s_reg.rx_lvl;
					s_next.start_bit_seen = 1'b0;
					s_next.first_bit_seen = 1'b0;
					s_next.rx_state = s_reg.rx_lvl ? RX_IDLE : RX_WAIT_HIGH;
				end
			end
			RX_WAIT_HIGH: begin
				if (s_reg.rx_lvl) begin
					s_next.rx_state = RX_IDLE;
				end
			end
			default: s_next.rx_state = RX_IDLE;
		endcase

		if (reset_cmd) begin
			s_next.tx_shifter_empty = 1'b1;
			s_next.tx_holding_empty = 1'b1;
			s_next.break_request = 1'b0;
			s_next.request_send_control = 1'b0;
			s_next.rts_n = 1'b1;
			s_next.serial_tx_line = 1'b1;
			s_next.tx_state = TX_IDLE;
			s_next.rx_state = RX_IDLE;
			s_next.rx_holding_full = 1'b0;
			s_next.start_bit_seen = 1'b0;
			s_next.first_bit_seen = 1'b0;
			s_next.timer_expired_flag = 1'b0;
			s_next.timer_overrun_flag = 1'b0;
			s_next.timer_cnt = cfg.interval;
			s_next.pre_cnt = PRESCALE_LAST;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_reg <= '0;
			s_reg.rx_s <= 3'h7;
			s_reg.cts_s <= 3'h7;
			s_reg.dsr_s <= 3'h7;
			s_reg.rx_lvl <= 1'b1;
			s_reg.rx_prev <= 1'b1;
			s_reg.cts_lvl <= 1'b1;
			s_reg.dsr_lvl <= 1'b1;
			s_reg.tx_holding_empty <= 1'b1;
			s_reg.tx_shifter_empty <= 1'b1;
			s_reg.serial_tx_line <= 1'b1;
			s_reg.rts_n <= 1'b1;
			s_reg.tx_state <= TX_IDLE;
			s_reg.rx_state <= RX_IDLE;
			s_reg.pre_cnt <= PRESCALE_LAST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign serial_tx_line = s_reg.serial_tx_line;
	assign rts_n = s_reg.rts_n;
	assign cru_rdata = s_reg.rdata;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence seq_reset_cmd;
		cru_req.we && cru_req.addr == WR_RESET;
	endsequence
	sequence seq_rts_on;
		cru_req.we && cru_req.addr == WR_RTS && cru_req.wdata;
	endsequence

	a_idle_line_high: assert property (s_reg.tx_shifter_empty &&
		s_reg.tx_state != TX_BREAK |-> s_reg.serial_tx_line)
		else $error("line low while shifter empty");
	a_reset_cmd_idle: assert property (seq_reset_cmd |=>
		s_reg.tx_shifter_empty && s_reg.tx_holding_empty && s_reg.rts_n &&
		!s_reg.break_request && s_reg.serial_tx_line)
		else $error("reset command did not idle transmitter");
	a_rts_goes_low: assert property (seq_rts_on ##1 !reset_cmd |=>
		!s_reg.rts_n)
		else $error("RTS not driven low");
	a_holding_load: assert property (cru_req.we &&
		cru_req.addr == WR_TXB_TOP && s_reg.tx_state != TX_BREAK &&
		!reset_cmd |=> !s_reg.tx_holding_empty)
		else $error("holding empty not cleared by load");
	a_start_bit_low: assert property ($fell(s_reg.tx_shifter_empty) |->
		!s_reg.serial_tx_line && s_reg.tx_state == TX_START)
		else $error("character does not open with start bit");
	a_break_holds_low: assert property (s_reg.tx_state == TX_BREAK &&
		s_reg.break_request && !reset_cmd |=>
		!s_reg.serial_tx_line)
		else $error("line not low during break");
	a_rts_release: assert property ($rose(s_reg.rts_n) |->
		$past(reset_cmd) || (s_reg.tx_shifter_empty &&
		!s_reg.break_request))
		else $error("RTS released with work pending");
	a_timer_overrun: assert property (timer_hit && s_reg.timer_expired_flag
		&& !reset_cmd |=> s_reg.timer_overrun_flag)
		else $error("timer overrun not flagged");
	a_tx_irq_read: assert property (!cru_req.we &&
		cru_req.addr == 5'(RD_TX_IRQ) |=>
		cru_rdata == $past(s_reg.tx_holding_empty
		&& s_reg.tx_irq_enable))
		else $error("transmit interrupt status wrong");
endmodule

// *** test/modem_model.sv ***
`timescale 1ns/1ps
module modem_model #(
	parameter int BIT = 8
) (
	input wire logic clk_sys,
	input wire logic serial_tx_line,
	output logic serial_rx_line,
	output logic cts_n,
	output logic dsr_n
);
	logic [7:0] got;
	logic [7:0] q[$];
	initial begin
		serial_rx_line = 1'b1;
		cts_n = 1'b1;
		dsr_n = 1'b1;
		got = 8'h00;
	end
	// Frame toward the device: start, 8 bits LSB first, one stop
	task automatic send(input logic [7:0] d, input logic stop);
		for (int i = 0; i < 10; i++) begin
			serial_rx_line <= (i == 0) ? 1'b0 : (i == 9) ? stop : d[i-1];
			repeat (BIT) @(negedge clk_sys);
		end
		serial_rx_line <= 1'b1;
		repeat (BIT) @(negedge clk_sys);
	endtask
	// Mid-bit sampling; a frame with a low stop (a break) is not kept
	always begin
		@(negedge serial_tx_line);
		repeat (BIT / 2) @(posedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk_sys);
			got[i] = serial_tx_line;
		end
		repeat (BIT) @(posedge clk_sys);
		if (serial_tx_line === 1'b1)
			q.push_back(got);
		wait (serial_tx_line === 1'b1);
	end
endmodule

// *** test/async_serial_tx_and_status_tb.sv ***
`timescale 1ns/1ps
module async_serial_tx_and_status_tb;
	import serial_pkg::*;
	localparam int BIT = 8;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	cru_req_t cru_req = '0;
	// 8 data bits, one stop, no parity, short timer period
	cfg_t cfg = {4'b1110, 2'b00, 16'h0008, 8'h02};
	logic cru_rdata;
	logic serial_rx_line;
	logic cts_n;
	logic dsr_n;
	logic serial_tx_line;
	logic rts_n;
	int failures = 0;
	int checks_done = 0;
	always #25 clk_sys = ~clk_sys;
	serial_tx_status i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.cru_req(cru_req), .cru_rdata(cru_rdata), .cfg(cfg),
		.serial_rx_line(serial_rx_line), .cts_n(cts_n), .dsr_n(dsr_n),
		.serial_tx_line(serial_tx_line), .rts_n(rts_n));
	modem_model #(.BIT(BIT)) i_modem (.clk_sys(clk_sys),
		.serial_tx_line(serial_tx_line), .serial_rx_line(serial_rx_line),
		.cts_n(cts_n), .dsr_n(dsr_n));
	task automatic results();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [7:0] g, input logic [7:0] e,
		input string w);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("mismatch at %0t: %s got %h exp %h", $time, w, g, e);
		end
	endtask
	// Writes leave a idle cycle so the strobe is never set twice in a step
	task automatic wr(input logic [4:0] a, input logic v);
		cru_req = '{we: 1'b1, addr: a, wdata: v};
		@(negedge clk_sys);
		cru_req.we = 1'b0;
		@(negedge clk_sys);
	endtask
	task automatic rdc(input int a, input logic e, input string w);
		cru_req.addr = 5'(a);
		@(negedge clk_sys);
		check({7'h00, cru_rdata}, {7'h00, e}, w);
	endtask
	task automatic rd8(input logic [7:0] e);
		for (int i = 0; i < 8; i++)
			rdc(i, e[i], "rx byte bit");
	endtask
	// Bit 7 goes last since its write queues the character
	task automatic load(input logic [7:0] d);
		for (int i = 0; i < 8; i++)
			wr(5'(i), d[i]);
	endtask
	task automatic wait_rx(input int n);
		int k;
		k = 0;
		while (i_modem.q.size() < n && k < 3000) begin
			@(negedge clk_sys);
			k++;
		end
		if (k == 3000) begin
			failures++;
			$display("mismatch at %0t: no character on line", $time);
			results();
		end
	endtask
	task automatic t_tx();
		i_modem.cts_n = 1'b0;
		load(8'h5A);
		repeat (20 * BIT) @(negedge clk_sys);
		check(8'(i_modem.q.size()), 8'h00, "sent without rts");
		check({7'h00, serial_tx_line}, 8'h01, "idle line");
		wr(WR_RTS, 1'b1);
		check({7'h00, rts_n}, 8'h00, "rts on");
		wait_rx(1);
		check(i_modem.q[0], 8'h5A, "first char");
		load(8'h81);
		load(8'h7E);
		wait_rx(3);
		check(i_modem.q[1], 8'h81, "pair a");
		check(i_modem.q[2], 8'h7E, "pair b");
		// The model keeps a character at mid stop bit, before the end
		repeat (BIT) @(negedge clk_sys);
		rdc(RD_TXSE, 1'b1, "shifter empty");
		rdc(RD_TXHE, 1'b1, "holding empty");
		i_modem.cts_n = 1'b1;
		load(8'h33);
		repeat (20 * BIT) @(negedge clk_sys);
		check(8'(i_modem.q.size()), 8'h03, "sent with cts off");
		i_modem.cts_n = 1'b0;
		wait_rx(4);
		check(i_modem.q[3], 8'h33, "after cts");
	endtask
	task automatic t_break();
		load(8'hC3);
		wr(WR_BREAK, 1'b1);
		wait_rx(5);
		check(i_modem.q[4], 8'hC3, "char before break");
		// Long enough for the model to drop the break as a bad frame
		repeat (12 * BIT) @(negedge clk_sys);
		check({7'h00, serial_tx_line}, 8'h00, "break low");
		rdc(RD_TXSE, 1'b1, "shifter empty in break");
		wr(WR_BREAK, 1'b0);
		repeat (4) @(negedge clk_sys);
		check({7'h00, serial_tx_line}, 8'h01, "break end");
	endtask
	task automatic t_rts_off();
		load(8'h99);
		wr(WR_RTS, 1'b0);
		check({7'h00, rts_n}, 8'h00, "rts held");
		wait_rx(6);
		check(i_modem.q[5], 8'h99, "last char");
		repeat (3 * BIT) @(negedge clk_sys);
		check({7'h00, rts_n}, 8'h01, "rts off");
		load(8'h11);
		repeat (20 * BIT) @(negedge clk_sys);
		check(8'(i_modem.q.size()), 8'h06, "sent after off");
	endtask
	task automatic t_rx();
		i_modem.send(8'h3C, 1'b1);
		rdc(RD_RXFULL, 1'b1, "rx full");
		rd8(8'h3C);
		rdc(RD_FRAME, 1'b0, "no frame err");
		wr(WR_RX_EN, 1'b1);
		rdc(RD_RXFULL, 1'b0, "rx cleared");
		rdc(RD_RX_IRQ, 1'b0, "rx irq idle");
		i_modem.send(8'hC5, 1'b1);
		rdc(RD_RX_IRQ, 1'b1, "rx irq");
		rdc(RD_OVER, 1'b0, "no overrun");
		i_modem.send(8'h0F, 1'b1);
		rdc(RD_OVER, 1'b1, "overrun");
		rdc(RD_ANYERR, 1'b1, "any error");
		rd8(8'h0F);
		wr(WR_RX_EN, 1'b1);
		i_modem.send(8'h55, 1'b0);
		rdc(RD_FRAME, 1'b1, "frame err");
		rdc(RD_OVER, 1'b0, "overrun gone");
		rdc(RD_RXLINE, 1'b1, "rx line");
	endtask
	task automatic t_modem();
		wr(WR_MODEM_EN, 1'b1);
		rdc(RD_MODEM_IRQ, 1'b0, "modem irq clear");
		i_modem.dsr_n = 1'b0;
		repeat (8) @(negedge clk_sys);
		rdc(RD_MODEM_LINE_CHANGED, 1'b1, "modem change");
		rdc(RD_MODEM_IRQ, 1'b1, "modem irq");
		wr(WR_MODEM_EN, 1'b0);
		rdc(RD_MODEM_IRQ, 1'b0, "modem irq off");
	endtask
	task automatic t_timer();
		wr(WR_TIMER_EN, 1'b1);
		repeat (140) @(negedge clk_sys);
		rdc(RD_TIMELAPSE, 1'b1, "elapsed");
		rdc(RD_TIMER_IRQ, 1'b1, "timer irq");
		repeat (130) @(negedge clk_sys);
		rdc(RD_TIMEOVR, 1'b1, "timer error");
		wr(WR_TIMER_EN, 1'b1);
		rdc(RD_TIMEOVR, 1'b0, "timer error clear");
	endtask
	// 7 data bits, even parity, two stop bits; the model reads the
	// parity bit as its eighth bit
	task automatic t_frame();
		cfg = {4'b1001, 2'b10, 16'h0008, 8'h02};
		wr(WR_TX_EN, 1'b1);
		rdc(RD_TX_IRQ, 1'b1, "tx irq");
		wr(WR_TX_EN, 1'b0);
		rdc(RD_TX_IRQ, 1'b0, "tx irq off");
		wr(WR_RTS, 1'b1);
		load(8'h07);
		wait_rx(7);
		check(i_modem.q[6], 8'h87, "parity frame");
		repeat (BIT) @(negedge clk_sys);
		rdc(RD_TXSE, 1'b0, "second stop bit");
		i_modem.send(8'h87, 1'b1);
		rdc(RD_PAR, 1'b0, "parity good");
		rd8(8'h07);
		i_modem.send(8'h07, 1'b1);
		rdc(RD_PAR, 1'b1, "parity bad");
	endtask
	initial begin
		repeat (6) @(negedge clk_sys);
		rst_n = 1'b1;
		@(negedge clk_sys);
		rdc(RD_TXSE, 1'b1, "reset shifter");
		rdc(RD_TXHE, 1'b1, "reset holding");
		check({6'h00, rts_n, serial_tx_line}, 8'h03, "reset pins");
		t_tx();
		t_break();
		t_rts_off();
		t_rx();
		t_modem();
		t_timer();
		wr(WR_RESET, 1'b0);
		rdc(RD_TXHE, 1'b1, "cmd holding");
		check({6'h00, rts_n, serial_tx_line}, 8'h03, "cmd pins");
		t_frame();
		results();
	end
endmodule
